// file: hw/fsr_regs.vh
// Purpose: Constants for the FIFO read port and reset-time configuration
// Assumes: Included by bare name from the design files
// Notes: Offsets, field positions, reset values and counts
//
// Behaviour
// - Fall-through select caught at full reset: low standard, high fall-through
// - Read request low and not empty loads next word each edge
// - Read request high holds output register and data outputs, except the first fall-through word
// - Standard mode: every word requested; empty flag low after last
// - Standard mode: empty flag releases two cycles plus skew after write
// - Fall-through: first word appears on third edge after write
// - Fall-through: true read after last word sets ready high, blocks reads
// - Serial method: one bit per rising shift clock edge, gate and access low
// - Serial load gate high leaves offsets unchanged
// - Drive enable low drives output register; high floats the bus
// - Data outputs follow port select one edge later
// - After reset with drive enable low, drive until first edge after
// - Port select high ignores reads and moves no word
// - Flags and first fall-through word ignore port select
// - Access input and two picks choose default offsets and method
// - After reset access low loads or reads offsets; readback parallel
// - Width selects caught at full reset; flags count long words
// - Byte order select low big-endian, high little-endian
// - Timing select low: split assert and release clock edges
// - Timing select high: each flag updated from its own side
// - Parity layout high strips nine-bit lane parity; low ignores top byte
`ifndef FSR_REGS_VH
`define FSR_REGS_VH
`define FSR_DW 72
`define FSR_AW 9
`define FSR_PW 10
`define FSR_DEPTH 10'h0200
`define FSR_A_CTRL 8'h00
`define FSR_A_STATUS 8'h04
`define FSR_A_LEVEL 8'h08
`define FSR_A_OFFS 8'h0C
`define FSR_SKEW_RST 2'h0
`define FSR_OFS_D0 9'h007
`define FSR_OFS_D1 9'h00F
`define FSR_OFS_D2 9'h01F
`define FSR_OFS_D3 9'h07F
`define FSR_NPIN 17
`define FSR_P_REQ 0
`define FSR_P_RCS 1
`define FSR_P_OE 2
`define FSR_P_SEN 3
`define FSR_P_LD 4
`define FSR_P_SCLK 5
`define FSR_P_FTS 6
`define FSR_P_PK0 7
`define FSR_P_PK1 8
`define FSR_P_BM 9
`define FSR_P_IW 10
`define FSR_P_OW 11
`define FSR_P_BO 12
`define FSR_P_FT 13
`define FSR_P_IP 14
`define FSR_P_FRS 15
`define FSR_P_PRS 16
`endif

// file: hw/fsr_sync.v
// Purpose: Two-stage synchroniser for a vector of pin inputs
// Assumes: Pins are static for at least two clocks per change
// Notes: Only the second stage leaves this module
`timescale 1ns/100ps
`default_nettype none
module fsr_sync #(
   parameter W = 1
) (
   input wire core_clk,
   input wire reset,
   input wire clk_en,
   input wire [W-1:0] din,
   output reg [W-1:0] dout
);
   reg [W-1:0] meta_q;
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         meta_q <= {W{1'b1}};
         dout <= {W{1'b1}};
      end
      else if (clk_en)
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule // fsr_sync
`default_nettype wire

// file: hw/fsr_ram.v
// Purpose: Word store for the FIFO with registered read data
// Assumes: Read and write never target one address in one cycle
// Notes: Read data lags the address by one edge
`timescale 1ns/100ps
`default_nettype none
module fsr_ram #(
   parameter W = 72,
   parameter A = 9
) (
   input wire core_clk,
   input wire clk_en,
   input wire we,
   input wire [A-1:0] waddr,
   input wire [W-1:0] wdata,
   input wire [A-1:0] raddr,
   output reg [W-1:0] rdata
);
   reg [W-1:0] mem [0:(1<<A)-1];
   always @(posedge core_clk)
   begin
      if (clk_en)
      begin
         if (we)
            mem[waddr] <= wdata;
         rdata <= mem[raddr];
      end
   end
endmodule // fsr_ram
`default_nettype wire

// file: hw/fsr_read_port.v
// Purpose: Read port, flags and reset-time configuration of a FIFO
// Assumes: Write side logic runs on core_clk; host pins are asynchronous
// Notes: Pin inputs add two cycles of latency through the synchroniser
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fsr_regs.vh"
module fsr_read_port (
   input wire core_clk,
   input wire reset,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire wr_valid,
   input wire [71:0] wr_data,
   output reg wr_full,
   input wire read_req_n,
   input wire read_port_select_n,
   input wire output_drive_n,
   input wire serial_load_gate_n,
   input wire offset_access_n,
   input wire shift_clk,
   input wire fall_through_select,
   input wire default_offset_pick0,
   input wire default_offset_pick1,
   input wire bus_matching_select,
   input wire input_width_select,
   input wire output_width_select,
   input wire byte_order_select_n,
   input wire flag_timing_select,
   input wire parity_layout_select,
   input wire full_reset_n,
   input wire partial_reset_n,
   output reg [71:0] read_data_out,
   output reg read_data_oe_n,
   output reg empty_indicator_n,
   output reg almost_empty_n,
   output reg almost_full_n
);
   // Width code: 0 one part, 1 two parts, 2 four parts
   function [6:0] shamt;
      input [1:0] pos;
      input [1:0] code;
      begin
         case (code)
            2'h1: shamt = pos[0] ? 7'd36 : 7'd0;
            2'h2: shamt = {1'b0, pos, 4'h0} + {2'h0, pos, 1'b0};
            default: shamt = 7'd0;
         endcase
      end
   endfunction
   function [71:0] lmask;
      input [1:0] code;
      begin
         case (code)
            2'h1: lmask = {36'h0, {36{1'b1}}};
            2'h2: lmask = {54'h0, {18{1'b1}}};
            default: lmask = {72{1'b1}};
         endcase
      end
   endfunction
   function [1:0] lastp;
      input [1:0] code;
      begin
         lastp = (code == 2'h2) ? 2'h3 : ((code == 2'h1) ? 2'h1 : 2'h0);
      end
   endfunction
   // Big-endian sends the most significant part first
   function [1:0] ppos;
      input [1:0] idx;
      input [1:0] code;
      input little;
      begin
         ppos = little ? idx : lastp(code) - idx;
      end
   endfunction
   function [71:0] slice;
      input [71:0] lw;
      input [1:0] idx;
      input [1:0] code;
      input little;
      begin
         slice = (lw >> shamt(ppos(idx, code, little), code)) & lmask(code);
      end
   endfunction
   function [71:0] place;
      input [71:0] d;
      input [1:0] idx;
      input [1:0] code;
      input little;
      begin
         place = (d & lmask(code)) << shamt(ppos(idx, code, little), code);
      end
   endfunction

   wire [`FSR_NPIN-1:0] pins_s;
   fsr_sync #(.W(`FSR_NPIN)) u_sync (
      .core_clk(core_clk),
      .reset(reset),
      .clk_en(clk_en),
      .din({partial_reset_n, full_reset_n, parity_layout_select,
            flag_timing_select, byte_order_select_n, output_width_select,
            input_width_select, bus_matching_select, default_offset_pick1,
            default_offset_pick0, fall_through_select, shift_clk,
            offset_access_n, serial_load_gate_n, output_drive_n,
            read_port_select_n, read_req_n}),
      .dout(pins_s)
   );

   wire req_n_s = pins_s[`FSR_P_REQ];
   wire rcs_n_s = pins_s[`FSR_P_RCS];
   wire oe_n_s = pins_s[`FSR_P_OE];
   wire sen_n_s = pins_s[`FSR_P_SEN];
   wire ld_n_s = pins_s[`FSR_P_LD];
   wire full_rst = reset | ~pins_s[`FSR_P_FRS];
   wire any_rst = full_rst | ~pins_s[`FSR_P_PRS];

   // Configuration caught at full reset
   reg ftm_q, serial_q, little_q, ftime_q, parity_q;
   reg [1:0] in_code_q, out_code_q;
   reg [8:0] ae_ofs_q, af_ofs_q;
   reg [1:0] skew_q;
   reg sclk_q, post_rst_q;
   reg [`FSR_PW-1:0] wptr_q, rptr_q, rptr_d;
   reg [`FSR_PW-1:0] wp0_q, wp1_q, wp2_q, wp3_q, rp0_q, rp1_q;
   reg [1:0] in_part_q, part_q, part_d;
   reg [71:0] pack_q, lw_q, lw_d, q_d;
   reg lw_valid_q, lw_valid_d, ov_q, ov_d, words_q, words_d;
   reg advance, have_next, have_d;
   wire [71:0] ram_q;
   wire [`FSR_PW-1:0] wp_vis;
   wire [`FSR_PW-1:0] cnt_vis, cnt_w, cnt_r;
   wire [`FSR_PW-1:0] e_thr, f_lim;
   wire [8:0] ofs_pick;
   wire wr_take, lw_done, ofs_par_wr, rd_true, ofs_rd, sclk_rise;
   wire [71:0] in_word, ofs_word;
   wire [63:0] wr_payload;
   integer k;
   reg [63:0] strip_v;
   reg [71:0] expand_v;

   assign ofs_pick = pins_s[`FSR_P_PK1] ?
      (pins_s[`FSR_P_PK0] ? `FSR_OFS_D3 : `FSR_OFS_D2) :
      (pins_s[`FSR_P_PK0] ? `FSR_OFS_D1 : `FSR_OFS_D0);

   always @(posedge core_clk)
   begin
      if (reset)
      begin
         ftm_q <= 1'b0;
         serial_q <= 1'b0;
         little_q <= 1'b0;
         ftime_q <= 1'b0;
         parity_q <= 1'b0;
         in_code_q <= 2'h0;
         out_code_q <= 2'h0;
      end
      else if (clk_en && full_rst)
      begin
         ftm_q <= pins_s[`FSR_P_FTS];
         serial_q <= ld_n_s;
         little_q <= pins_s[`FSR_P_BO];
         ftime_q <= pins_s[`FSR_P_FT];
         parity_q <= pins_s[`FSR_P_IP];
         // Only one side narrows; the other stays full width
         in_code_q <= !pins_s[`FSR_P_BM] ? 2'h0 :
            (pins_s[`FSR_P_IW] ? {pins_s[`FSR_P_OW], ~pins_s[`FSR_P_OW]}
             : 2'h0);
         out_code_q <= !pins_s[`FSR_P_BM] ? 2'h0 :
            (pins_s[`FSR_P_IW] ? 2'h0
             : {pins_s[`FSR_P_OW], ~pins_s[`FSR_P_OW]});
      end
   end

   // Parity lanes stripped from a parallel offset word
   always @*
   begin
      strip_v = 64'h0000_0000_0000_0000;
      expand_v = 72'h00_0000_0000_0000_0000;
      for (k = 0; k < 8; k = k + 1)
      begin
         strip_v[8*k +: 8] = wr_data[9*k +: 8];
         expand_v[9*k +: 8] = ofs_word[8*k +: 8];
         expand_v[9*k+8] = ^ofs_word[8*k +: 8];
      end
   end
   assign wr_payload = parity_q ? strip_v : wr_data[63:0];
   assign ofs_word = {47'h0, af_ofs_q, 7'h00, ae_ofs_q};

   // Offsets: defaults at full reset, then serial or parallel loading
   assign sclk_rise = pins_s[`FSR_P_SCLK] & ~sclk_q;
   assign ofs_par_wr = wr_valid & ~ld_n_s & ~serial_q & ~any_rst;
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         ae_ofs_q <= `FSR_OFS_D0;
         af_ofs_q <= `FSR_OFS_D0;
         sclk_q <= 1'b1;
      end
      else if (clk_en)
      begin
         sclk_q <= pins_s[`FSR_P_SCLK];
         if (full_rst)
         begin
            ae_ofs_q <= ofs_pick;
            af_ofs_q <= ofs_pick;
         end
         else if (ofs_par_wr)
         begin
            ae_ofs_q <= wr_payload[8:0];
            af_ofs_q <= wr_payload[24:16];
         end
         // Shift chain runs from the almost-full field into almost-empty
         else if (serial_q && sclk_rise && !sen_n_s && !ld_n_s)
            {ae_ofs_q, af_ofs_q} <= {ae_ofs_q[7:0], af_ofs_q,
                                     pins_s[`FSR_P_FTS]};
      end
   end

   // Write side packing into long words
   assign wr_take = wr_valid & ~wr_full & ld_n_s & ~any_rst;
   assign lw_done = wr_take & (in_part_q == lastp(in_code_q));
   assign in_word = pack_q | place(wr_data, in_part_q, in_code_q, little_q);
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         wptr_q <= 10'h000;
         in_part_q <= 2'h0;
         pack_q <= 72'h00_0000_0000_0000_0000;
      end
      else if (clk_en)
      begin
         if (any_rst)
         begin
            wptr_q <= 10'h000;
            in_part_q <= 2'h0;
            pack_q <= 72'h00_0000_0000_0000_0000;
         end
         else if (lw_done)
         begin
            wptr_q <= wptr_q + 10'h001;
            in_part_q <= 2'h0;
            pack_q <= 72'h00_0000_0000_0000_0000;
         end
         else if (wr_take)
         begin
            in_part_q <= in_part_q + 2'h1;
            pack_q <= in_word;
         end
      end
   end

   // Delayed pointer views stand in for the clock-domain crossing
   assign wp_vis = (skew_q == 2'h0) ? wp0_q :
      (skew_q == 2'h1) ? wp1_q : (skew_q == 2'h2) ? wp2_q : wp3_q;
   assign cnt_vis = wp_vis - rptr_q;
   assign cnt_w = wptr_q - rp1_q;
   assign cnt_r = wptr_q - rptr_q;
   assign e_thr = {1'b0, ae_ofs_q} + {9'h000, ftm_q};
   assign f_lim = `FSR_DEPTH - {1'b0, af_ofs_q};

   // Read side next state
   assign rd_true = ~req_n_s & ~rcs_n_s;
   assign ofs_rd = rd_true & ~ld_n_s;
   always @*
   begin
      rptr_d = rptr_q;
      part_d = part_q;
      lw_d = lw_q;
      lw_valid_d = lw_valid_q;
      ov_d = ov_q;
      q_d = read_data_out;
      advance = 1'b0;
      have_next = (lw_valid_q && part_q != lastp(out_code_q)) || words_q;
      if (ftm_q)
      begin
         if (!ov_q)
            advance = have_next;
         else if (rd_true && ld_n_s)
         begin
            advance = have_next;
            ov_d = have_next;
         end
         if (advance)
            ov_d = 1'b1;
      end
      else
         advance = rd_true & ld_n_s & have_next;
      if (advance)
      begin
         if (lw_valid_q && part_q != lastp(out_code_q))
            part_d = part_q + 2'h1;
         else
         begin
            lw_d = ram_q;
            part_d = 2'h0;
            lw_valid_d = 1'b1;
            rptr_d = rptr_q + 10'h001;
         end
         q_d = slice(lw_d, part_d, out_code_q, little_q);
      end
      else if (ofs_rd)
         q_d = parity_q ? expand_v : ofs_word;
      words_d = (wp_vis != rptr_d);
      have_d = (lw_valid_d && part_d != lastp(out_code_q)) || words_d;
   end

   fsr_ram #(.W(`FSR_DW), .A(`FSR_AW)) u_ram (
      .core_clk(core_clk),
      .clk_en(clk_en),
      .we(lw_done),
      .waddr(wptr_q[`FSR_AW-1:0]),
      .wdata(in_word),
      .raddr(rptr_d[`FSR_AW-1:0]),
      .rdata(ram_q)
   );

   always @(posedge core_clk)
   begin
      if (reset)
      begin
         rptr_q <= 10'h000;
         wp0_q <= 10'h000;
         wp1_q <= 10'h000;
         wp2_q <= 10'h000;
         wp3_q <= 10'h000;
         rp0_q <= 10'h000;
         rp1_q <= 10'h000;
         part_q <= 2'h0;
         lw_q <= 72'h00_0000_0000_0000_0000;
         lw_valid_q <= 1'b0;
         ov_q <= 1'b0;
         words_q <= 1'b0;
         read_data_out <= 72'h00_0000_0000_0000_0000;
         empty_indicator_n <= 1'b0;
         almost_empty_n <= 1'b0;
         almost_full_n <= 1'b1;
         wr_full <= 1'b0;
      end
      else if (clk_en)
      begin
         if (any_rst)
         begin
            rptr_q <= 10'h000;
            wp0_q <= 10'h000;
            wp1_q <= 10'h000;
            wp2_q <= 10'h000;
            wp3_q <= 10'h000;
            rp0_q <= 10'h000;
            rp1_q <= 10'h000;
            part_q <= 2'h0;
            lw_valid_q <= 1'b0;
            ov_q <= 1'b0;
            words_q <= 1'b0;
            read_data_out <= 72'h00_0000_0000_0000_0000;
            // Empty low in standard mode, ready high in fall-through
            empty_indicator_n <= full_rst ? pins_s[`FSR_P_FTS] : ftm_q;
            almost_empty_n <= 1'b0;
            almost_full_n <= 1'b1;
            wr_full <= 1'b0;
         end
         else
         begin
            wp0_q <= wptr_q;
            wp1_q <= wp0_q;
            wp2_q <= wp1_q;
            wp3_q <= wp2_q;
            rp0_q <= rptr_q;
            rp1_q <= rp0_q;
            rptr_q <= rptr_d;
            part_q <= part_d;
            lw_q <= lw_d;
            lw_valid_q <= lw_valid_d;
            ov_q <= ov_d;
            words_q <= words_d;
            read_data_out <= q_d;
            empty_indicator_n <= ftm_q ? ~ov_d : have_d;
            wr_full <= (wptr_q + {9'h000, lw_done} - rp1_q) == `FSR_DEPTH;
            // Sync timing: each flag judged from its own side's view
            if (ftime_q)
            begin
               almost_empty_n <= cnt_vis > e_thr;
               almost_full_n <= cnt_w < f_lim;
            end
            // Async timing: assert from one side, release from the other
            else
            begin
               if (almost_empty_n)
                  almost_empty_n <= cnt_vis > e_thr;
               else
                  almost_empty_n <= cnt_r > e_thr;
               if (almost_full_n)
                  almost_full_n <= cnt_w < f_lim;
               else
                  almost_full_n <= cnt_r < f_lim;
            end
         end
      end
   end

   // Output drive; enable is low while the bus is driven
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         post_rst_q <= 1'b1;
         read_data_oe_n <= 1'b1;
      end
      else if (clk_en)
      begin
         post_rst_q <= any_rst;
         if (any_rst || post_rst_q)
            read_data_oe_n <= oe_n_s;
         else
            read_data_oe_n <= oe_n_s | rcs_n_s;
      end
   end

   // APB slave, zero wait states
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         skew_q <= `FSR_SKEW_RST;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && !penable)
         begin
            case (paddr)
               `FSR_A_CTRL: prdata <= {30'h0, skew_q};
               `FSR_A_STATUS: prdata <= {18'h0, ov_q, wr_full,
                  almost_full_n, almost_empty_n, empty_indicator_n,
                  out_code_q, in_code_q, parity_q, ftime_q, little_q,
                  serial_q, ftm_q};
               `FSR_A_LEVEL: prdata <= {22'h0, cnt_vis};
               `FSR_A_OFFS: prdata <= {7'h0, af_ofs_q, 7'h0, ae_ofs_q};
               default: pslverr <= 1'b1;
            endcase
         end
         if (psel && penable && pready && pwrite && paddr == `FSR_A_CTRL)
            skew_q <= pwdata[1:0];
      end
   end
endmodule // fsr_read_port
`default_nettype wire

// file: testbench/fsr_read_port_properties.sv
// Purpose: Port checks for the FIFO read port
// Assumes: clk_en high; pins reach the logic three samples late
// Notes: Mode tracked from the strap while full reset is low
`timescale 1ns/100ps
`default_nettype none
module fsr_read_port_chk (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wr_valid,
   input wire logic wr_full,
   input wire logic read_req_n,
   input wire logic read_port_select_n,
   input wire logic output_drive_n,
   input wire logic offset_access_n,
   input wire logic fall_through_select,
   input wire logic full_reset_n,
   input wire logic partial_reset_n,
   input wire logic [71:0] read_data_out,
   input wire logic read_data_oe_n,
   input wire logic empty_indicator_n
);
   logic [2:0] up_q;
   logic [2:0] lo_q;
   logic ft_q;
   wire logic quiet = up_q == 3'h6;
   wire logic std = quiet && !ft_q;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   // Counters keep checks clear of synchroniser lag after any reset
   always @(posedge core_clk)
   begin
      up_q <= (reset || !full_reset_n || !partial_reset_n) ? 3'h0 :
         quiet ? up_q : up_q + 3'h1;
      lo_q <= (reset || full_reset_n) ? 3'h0 :
         (lo_q == 3'h6) ? lo_q : lo_q + 3'h1;
      ft_q <= reset ? 1'b0 : full_reset_n ? ft_q : fall_through_select;
   end
   chk_oe_follow: assert property (quiet |->
      read_data_oe_n == ($past(output_drive_n, 3) | $past(read_port_select_n, 3)))
      else $error("drive enable not following select");
   chk_oe_float: assert property (quiet && $past(output_drive_n, 3) |->
      read_data_oe_n)
      else $error("bus driven while drive enable high");
   chk_oe_in_reset: assert property (lo_q == 3'h6 |->
      read_data_oe_n == $past(output_drive_n, 3))
      else $error("drive enable wrong during full reset");
   chk_req_hold: assert property (std && $past(read_req_n, 3) |->
      $stable(read_data_out))
      else $error("output changed without request");
   chk_select_blocks: assert property (std && $past(read_port_select_n, 3)
      |-> $stable(read_data_out))
      else $error("output changed with port deselected");
   chk_empty_release: assert property (std && !empty_indicator_n &&
      wr_valid && !wr_full && $past(offset_access_n, 2) |->
      ##[2:3] empty_indicator_n)
      else $error("empty indicator late after write");
   chk_ft_first: assert property (quiet && ft_q && empty_indicator_n &&
      wr_valid && !wr_full && $past(offset_access_n, 2) |->
      ##[3:4] !empty_indicator_n)
      else $error("first word did not fall through");
   chk_apb_answer: assert property (psel && !penable |=> pready)
      else $error("no ready in access phase");
   chk_err_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("error outside access phase");
   cover property (quiet && !read_req_n && !read_port_select_n);
   cover property (ft_q && !empty_indicator_n);
   cover property (pslverr);
endmodule // fsr_read_port_chk
bind fsr_read_port fsr_read_port_chk fsr_read_port_chk_inst (
   .core_clk, .reset, .psel, .penable, .pready, .pslverr, .wr_valid,
   .wr_full, .read_req_n, .read_port_select_n, .output_drive_n,
   .fall_through_select, .full_reset_n, .partial_reset_n, .read_data_out,
   .read_data_oe_n, .empty_indicator_n, .offset_access_n);
`default_nettype wire

// file: testbench/fsr_host_model.sv
// Purpose: Host read-side pin driver
// Assumes: Commands change just after a clock edge
// Notes: Registered, so a pin moves one edge after its command
`timescale 1ns/100ps
`default_nettype none
module fsr_host_model (
   input wire logic core_clk,
   input wire logic fetch,
   input wire logic select,
   input wire logic drive,
   output logic read_req_n,
   output logic read_port_select_n,
   output logic output_drive_n
);
   initial
   begin
      read_req_n = 1'b1;
      read_port_select_n = 1'b1;
      output_drive_n = 1'b0;
   end
   // Select follows its own command each edge, independent of fetch
   always @(posedge core_clk)
   begin
      read_req_n <= !fetch;
      read_port_select_n <= !select;
      output_drive_n <= !drive;
   end
endmodule // fsr_host_model
`default_nettype wire

// file: testbench/fsr_read_port_tb.sv
// Purpose: Self-checking bench for the FIFO read port
// Assumes: x72 widths; offset access held high after full reset
// Notes: Pin effects waited out with fixed gaps past the synchroniser
`timescale 1ns/100ps
`default_nettype none
module fsr_read_port_tb;
   localparam logic [71:0] W_A = 72'h12_3456_789a_bcde_f012;
   localparam logic [71:0] W_B = 72'hfe_dcba_9876_5432_10ef;
   localparam logic [71:0] W_C = 72'ha5_a5a5_5a5a_0f0f_f0f0;
   localparam logic [71:0] W_D = 72'h3c_3c3c_c3c3_1234_5678;
   logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, wr_valid = 1'b0, fetch = 1'b0, select = 1'b0;
   logic drive = 1'b1, ld_n = 1'b1, frs_n = 1'b1, prs_n = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [71:0] wr_data = 72'h0;
   logic [4:0] strap = 5'h00;
   logic [1:0] pk = 2'h0;
   logic pready, pslverr, wr_full, read_data_oe_n, empty_indicator_n;
   logic almost_empty_n, almost_full_n;
   logic read_req_n, read_port_select_n, output_drive_n;
   logic [31:0] prdata;
   logic [71:0] read_data_out;
   int num_errors = 0;
   int n_tests = 0;
   always #50 core_clk = ~core_clk;
   fsr_host_model fsr_host_model_inst (.core_clk, .fetch, .select, .drive,
      .read_req_n, .read_port_select_n, .output_drive_n);
   fsr_read_port fsr_read_port_inst (
      .core_clk, .reset, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .wr_valid, .wr_data, .wr_full,
      .read_req_n, .read_port_select_n, .output_drive_n,
      .serial_load_gate_n(1'b1), .offset_access_n(ld_n), .shift_clk(1'b0),
      .fall_through_select(strap[0]), .default_offset_pick0(pk[0]),
      .default_offset_pick1(pk[1]), .bus_matching_select(1'b0),
      .input_width_select(pk[0]), .output_width_select(pk[1]),
      .byte_order_select_n(strap[2]), .flag_timing_select(strap[3]),
      .parity_layout_select(strap[4]), .full_reset_n(frs_n),
      .partial_reset_n(prs_n), .read_data_out, .read_data_oe_n,
      .empty_indicator_n, .almost_empty_n, .almost_full_n);
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic check(input logic [71:0] got, input logic [71:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      step(1);
      penable <= 1'b1;
      k = 0;
      do
      begin
         step(1);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20)
      begin
         num_errors++;
         tally_and_finish();
      end
      step(1);
   endtask
   task automatic wait_flag(input logic v);
      int k;
      for (k = 0; k < 30 && empty_indicator_n !== v; k++)
         step(1);
      if (k >= 30)
      begin
         num_errors++;
         tally_and_finish();
      end
   endtask
   // Strap order: parity, flag timing, byte order, access, fall-through
   task automatic do_full_reset(input logic [4:0] s, input logic [1:0] p);
      strap <= s;
      pk <= p;
      ld_n <= s[1];
      frs_n <= 1'b0;
      step(7);
      frs_n <= 1'b1;
      step(1);
      ld_n <= 1'b1;
      step(6);
   endtask
   task automatic pulse_read();
      fetch <= 1'b1;
      select <= 1'b1;
      step(1);
      fetch <= 1'b0;
      step(5);
   endtask
   task automatic test_config();
      logic [4:0] tbl [4] = '{5'h15, 5'h0a, 5'h1f, 5'h02};
      logic [8:0] dflt [4] = '{9'h007, 9'h00f, 9'h01f, 9'h07f};
      logic [31:0] rd;
      logic err;
      for (int i = 0; i < 4; i++)
      begin
         do_full_reset(tbl[i], i[1:0]);
         apb(1'b0, 8'h04, 32'h0, rd, err);
         check(72'(rd[4:0]), 72'(tbl[i]));
         apb(1'b0, 8'h0c, 32'h0, rd, err);
         check(72'(rd), 72'({7'h0, dflt[i], 7'h0, dflt[i]}));
      end
      apb(1'b1, 8'h00, 32'h0000_0001, rd, err);
      apb(1'b0, 8'h00, 32'h0, rd, err);
      check(72'(rd[1:0]), 72'h1);
      apb(1'b1, 8'h00, 32'h0, rd, err);
      apb(1'b0, 8'h10, 32'h0, rd, err);
      check(72'({err, rd}), 72'h1_0000_0000);
      $display("test_config done");
   endtask
   task automatic test_std_read();
      wr_data <= W_A;
      wr_valid <= 1'b1;
      step(1);
      wr_data <= W_B;
      step(1);
      wr_valid <= 1'b0;
      wait_flag(1'b1);
      check(72'({almost_empty_n, almost_full_n}), 72'h1);
      fetch <= 1'b1;
      step(6);
      check(read_data_out, 72'h0);
      fetch <= 1'b0;
      select <= 1'b1;
      step(6);
      check(read_data_out, 72'h0);
      pulse_read();
      check(read_data_out, W_A);
      pulse_read();
      check(read_data_out, W_B);
      check(72'(empty_indicator_n), 72'h0);
      pulse_read();
      check(read_data_out, W_B);
      $display("test_std_read done");
   endtask
   task automatic test_drive();
      for (int i = 0; i < 4; i++)
      begin
         drive <= i[0];
         select <= i[1];
         step(5);
         check(72'(read_data_oe_n), 72'(!(i[0] && i[1])));
      end
      $display("test_drive done");
   endtask
   task automatic test_ft();
      select <= 1'b0;
      do_full_reset(5'h03, 2'h3);
      wr_data <= W_C;
      wr_valid <= 1'b1;
      step(1);
      wr_valid <= 1'b0;
      wait_flag(1'b0);
      check(read_data_out, W_C);
      wr_data <= W_D;
      wr_valid <= 1'b1;
      step(1);
      wr_valid <= 1'b0;
      step(6);
      pulse_read();
      check(read_data_out, W_D);
      check(72'(empty_indicator_n), 72'h0);
      pulse_read();
      check(72'(empty_indicator_n), 72'h1);
      check(read_data_out, W_D);
      $display("test_ft done");
   endtask
   initial
   begin
      step(20);
      reset <= 1'b0;
      step(2);
      test_config();
      test_std_read();
      test_drive();
      test_ft();
      tally_and_finish();
   end
endmodule // fsr_read_port_tb
`default_nettype wire
